// file: core/cisr_pkg.sv
// cisr_pkg: constants, field layout and types for the comparator input select registers.
// assumes an 8-bit special-function-register bus with page, address and strobes.
package cisr_pkg;

  // register page and addresses on the special-function bus
  localparam logic [3:0] CISR_PAGE = 4'h0;
  localparam logic [7:0] CISR_CMP0_ADDR = 8'h9F;
  localparam logic [7:0] CISR_CMP1_ADDR = 8'h9E;

  // field positions
  localparam int CISR_NEG_MSB = 7;
  localparam int CISR_NEG_LSB = 4;
  localparam int CISR_POS_MSB = 3;
  localparam int CISR_POS_LSB = 0;

  // reset value: negative selects ground, positive selects the main rail
  localparam logic [7:0] CISR_RESET_VAL = 8'hFF;

  // number of comparators served
  localparam int CISR_NUM_CMP = 2;

  // special-function bus request from the core
  typedef struct packed {
    logic [3:0] page;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cisr_sfr_req_t;

  // one-hot analog source select for one comparator input
  // bits: [7:0] port pins in field order, [8] touch ref, [9] half supply,
  // [10] regulated supply or battery, [11] ground or main rail
  typedef struct packed {
    logic [11:0] neg_sel;
    logic [11:0] pos_sel;
  } cisr_mux_sel_t;

  localparam int CISR_SRC_TOUCH = 8;
  localparam int CISR_SRC_HALF = 9;
  localparam int CISR_SRC_SUPPLY = 10;
  localparam int CISR_SRC_RAIL = 11;

endpackage

// file: core/cisr_decode.sv
// cisr_decode: turns one 8-bit select register into one-hot analog mux selects.
// assumes the selects drive analog switches; a reserved code opens every switch of its own field.
`timescale 1ns/10ps
`default_nettype none
module cisr_decode (
  // register value
  input wire logic [7:0] sel_byte,
  // decoded selects
  output cisr_pkg::cisr_mux_sel_t mux_sel,
  output logic reserved_code
);
  import cisr_pkg::*;

  logic [3:0] neg_code; // upper nibble
  logic [3:0] pos_code; // lower nibble

  // one-hot decode of a nibble; codes 10xx give zero here, the caller masks negative 0111
  function automatic logic [11:0] nib_onehot(input logic [3:0] code);
    logic [11:0] res;
    res = 12'h000;
    if (code < 4'h8) begin
      res[code[2:0]] = 1'b1;
    end else if (code >= 4'hC) begin
      res[code - 4'h4] = 1'b1;
    end
    return res;
  endfunction

  // combinational decode of both fields
  always_comb begin
    neg_code = sel_byte[CISR_NEG_MSB:CISR_NEG_LSB];
    pos_code = sel_byte[CISR_POS_MSB:CISR_POS_LSB];
    mux_sel.neg_sel = nib_onehot(neg_code);
    // code 0111 of the negative field has no pin behind it
    if (neg_code == 4'h7) begin
      mux_sel.neg_sel = 12'h000;
    end
    mux_sel.pos_sel = nib_onehot(pos_code);
    reserved_code = (mux_sel.neg_sel == 12'h000) || (mux_sel.pos_sel == 12'h000);
  end

endmodule
`default_nettype wire

// file: core/cisr_regs.sv
// cisr_regs: the two comparator input select registers and their mux decode.
// assumes a single-cycle special-function bus from the core on clk.
`timescale 1ns/10ps
`default_nettype none
// Function
// - comparator-0 select at 0x9F, page 0, RW
// - comparator-1 select at 0x9E, page 0, RW
// - bits 7:4 pick negative pin source
// - bits 3:0 pick positive pin source
// - comparator-1 decodes exactly like comparator-0
// - negative internal sources; 0111, 10xx reserved
// - positive internal sources; 10xx reserved
module cisr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // special-function bus
  input wire cisr_pkg::cisr_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // analog mux selects, one per comparator
  output cisr_pkg::cisr_mux_sel_t cmp0_mux,
  output cisr_pkg::cisr_mux_sel_t cmp1_mux,
  // reserved code present in either field, one flag per register
  output logic cmp0_reserved,
  output logic cmp1_reserved
);
  import cisr_pkg::*;

  // stored select registers and next values
  logic [7:0] comparator0_input_select_reg, comparator0_input_select_next;
  logic [7:0] comparator1_input_select_reg, comparator1_input_select_next;
  // registered outputs
  logic [7:0] sfr_rdata_reg, sfr_rdata_next;
  logic sfr_hit_reg, sfr_hit_next;
  cisr_mux_sel_t cmp0_mux_reg, cmp1_mux_reg;
  logic cmp0_res_reg, cmp1_res_reg;
  // decoded selects from the next register values
  cisr_mux_sel_t dec_mux [CISR_NUM_CMP];
  logic dec_res [CISR_NUM_CMP];
  logic [7:0] dec_in [CISR_NUM_CMP];
  logic hit0, hit1;

  // address match on page and address
  function automatic logic addr_match(input cisr_sfr_req_t r, input logic [7:0] a);
    return (r.page == CISR_PAGE) && (r.addr == a);
  endfunction

  // write and read-back next values
  always_comb begin
    hit0 = addr_match(sfr_req, CISR_CMP0_ADDR);
    hit1 = addr_match(sfr_req, CISR_CMP1_ADDR);
    comparator0_input_select_next = comparator0_input_select_reg;
    comparator1_input_select_next = comparator1_input_select_reg;
    // every bit is writable, no reserved bits to mask
    if (sfr_req.wr && hit0) begin
      comparator0_input_select_next = sfr_req.wdata;
    end
    if (sfr_req.wr && hit1) begin
      comparator1_input_select_next = sfr_req.wdata;
    end
    // read data is zero off-address so it can be or-ed on the core bus
    sfr_rdata_next = 8'h00;
    sfr_hit_next = 1'b0;
    if (sfr_req.rd && hit0) begin
      sfr_rdata_next = comparator0_input_select_reg;
      sfr_hit_next = 1'b1;
    end else if (sfr_req.rd && hit1) begin
      sfr_rdata_next = comparator1_input_select_reg;
      sfr_hit_next = 1'b1;
    end
    dec_in[0] = comparator0_input_select_next;
    dec_in[1] = comparator1_input_select_next;
  end

  // one identical decoder per comparator, so both share one field map
  for (genvar g = 0; g < CISR_NUM_CMP; g++) begin : g_dec
    cisr_decode u_dec (
      .sel_byte(dec_in[g]),
      .mux_sel(dec_mux[g]),
      .reserved_code(dec_res[g])
    );
  end

  // register everything; selects are registered so the analog switches see
  // glitch-free levels, decoded from the next values so they change on the same edge that stores the write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      comparator0_input_select_reg <= CISR_RESET_VAL;
      comparator1_input_select_reg <= CISR_RESET_VAL;
      sfr_rdata_reg <= 8'h00;
      sfr_hit_reg <= 1'b0;
      // ground on the negative, main rail on the positive
      cmp0_mux_reg <= {12'h800, 12'h800};
      cmp1_mux_reg <= {12'h800, 12'h800};
      cmp0_res_reg <= 1'b0;
      cmp1_res_reg <= 1'b0;
    end else begin
      comparator0_input_select_reg <= comparator0_input_select_next;
      comparator1_input_select_reg <= comparator1_input_select_next;
      sfr_rdata_reg <= sfr_rdata_next;
      sfr_hit_reg <= sfr_hit_next;
      cmp0_mux_reg <= dec_mux[0];
      cmp1_mux_reg <= dec_mux[1];
      cmp0_res_reg <= dec_res[0];
      cmp1_res_reg <= dec_res[1];
    end
  end

  // outputs straight from flip-flops
  assign sfr_rdata = sfr_rdata_reg;
  assign sfr_hit = sfr_hit_reg;
  assign cmp0_mux = cmp0_mux_reg;
  assign cmp1_mux = cmp1_mux_reg;
  assign cmp0_reserved = cmp0_res_reg;
  assign cmp1_reserved = cmp1_res_reg;

  // checks on the bus side and on the decoded selects
  // a write strobe that lands on one of the two select registers
  sequence s_wr0;
    sfr_req.wr && sfr_req.page == CISR_PAGE && sfr_req.addr == CISR_CMP0_ADDR;
  endsequence
  sequence s_wr1;
    sfr_req.wr && sfr_req.page == CISR_PAGE && sfr_req.addr == CISR_CMP1_ADDR;
  endsequence
  // a plain read strobe on one of the two select registers
  sequence s_rd0;
    sfr_req.rd && !sfr_req.wr && sfr_req.page == CISR_PAGE && sfr_req.addr == CISR_CMP0_ADDR;
  endsequence
  sequence s_rd1;
    sfr_req.rd && !sfr_req.wr && sfr_req.page == CISR_PAGE && sfr_req.addr == CISR_CMP1_ADDR;
  endsequence

  a_write_cmp0_store: assert property (@(posedge clk) disable iff (reset)
    s_wr0 |=> comparator0_input_select_reg == $past(sfr_req.wdata))
    else $error("cmp0 select write not stored");
  a_write_cmp1_store: assert property (@(posedge clk) disable iff (reset)
    s_wr1 |=> comparator1_input_select_reg == $past(sfr_req.wdata))
    else $error("cmp1 select write not stored");
  a_read_cmp0_back: assert property (@(posedge clk) disable iff (reset)
    (s_wr0 ##1 (sfr_req.rd && !sfr_req.wr && sfr_req.page == CISR_PAGE
      && sfr_req.addr == CISR_CMP0_ADDR)) |=> sfr_rdata == $past(sfr_req.wdata, 2))
    else $error("cmp0 read-back mismatch");
  a_read_miss_zero: assert property (@(posedge clk) disable iff (reset)
    (sfr_req.rd && sfr_req.addr != CISR_CMP0_ADDR && sfr_req.addr != CISR_CMP1_ADDR)
      |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_neg_pin_route: assert property (@(posedge clk) disable iff (reset)
    (s_wr0 and sfr_req.wdata[7:4] == 4'h3) |=> cmp0_mux.neg_sel == 12'h008)
    else $error("negative code 0011 not routed to fourth pin");
  a_pos_pin_route: assert property (@(posedge clk) disable iff (reset)
    (s_wr0 and sfr_req.wdata[3:0] == 4'h7) |=> cmp0_mux.pos_sel == 12'h080)
    else $error("positive code 0111 not routed to eighth pin");
  a_same_decode: assert property (@(posedge clk) disable iff (reset)
    (comparator0_input_select_reg == comparator1_input_select_reg) |-> cmp0_mux == cmp1_mux)
    else $error("comparators decode differently");
  a_neg_reserved: assert property (@(posedge clk) disable iff (reset)
    (s_wr1 and sfr_req.wdata[7:4] == 4'h7) |=> cmp1_mux.neg_sel == 12'h000 && cmp1_reserved)
    else $error("negative 0111 not treated as reserved");
  a_neg_ground: assert property (@(posedge clk) disable iff (reset)
    (s_wr1 and sfr_req.wdata[7:4] == 4'hF) |=> cmp1_mux.neg_sel == 12'h800)
    else $error("negative 1111 not ground");
  a_pos_touch: assert property (@(posedge clk) disable iff (reset)
    (s_wr1 and sfr_req.wdata[3:0] == 4'hC) |=> cmp1_mux.pos_sel == 12'h100)
    else $error("positive 1100 not touch reference");
  a_reset_ones: assert property (@(posedge clk)
    $fell(reset) |-> comparator0_input_select_reg == CISR_RESET_VAL
      && comparator1_input_select_reg == CISR_RESET_VAL)
    else $error("select registers not all ones after reset");

  // bus side: back-to-back read of comparator 1, combined strobes, wrong page
  a_read_cmp1_back: assert property (@(posedge clk) disable iff (reset)
    (s_wr1 ##1 s_rd1) |=> sfr_hit && sfr_rdata == $past(sfr_req.wdata, 2))
    else $error("cmp1 read-back mismatch");
  a_read_both_old: assert property (@(posedge clk) disable iff (reset)
    (s_wr0 and sfr_req.rd) |=> sfr_rdata == $past(comparator0_input_select_reg)
      && comparator0_input_select_reg == $past(sfr_req.wdata))
    else $error("combined read and write mishandled");
  a_read_page_miss: assert property (@(posedge clk) disable iff (reset)
    (sfr_req.rd && sfr_req.page != CISR_PAGE) |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("read on another page returned data");
  a_write_page_miss: assert property (@(posedge clk) disable iff (reset)
    (sfr_req.wr && sfr_req.page != CISR_PAGE) |=> $stable(comparator0_input_select_reg)
      && $stable(comparator1_input_select_reg))
    else $error("write on another page changed a register");
  a_hit_one_cycle: assert property (@(posedge clk) disable iff (reset)
    !sfr_req.rd |=> !sfr_hit)
    else $error("read hit without a read strobe");

  // selects stand until the next write to their own register
  a_hold_cmp0: assert property (@(posedge clk) disable iff (reset)
    !(sfr_req.wr && sfr_req.page == CISR_PAGE && sfr_req.addr == CISR_CMP0_ADDR)
      |=> $stable(cmp0_mux) && $stable(cmp0_reserved))
    else $error("cmp0 selects moved without a write");
  a_hold_cmp1: assert property (@(posedge clk) disable iff (reset)
    !(sfr_req.wr && sfr_req.page == CISR_PAGE && sfr_req.addr == CISR_CMP1_ADDR)
      |=> $stable(cmp1_mux) && $stable(cmp1_reserved))
    else $error("cmp1 selects moved without a write");

  // negative field: internal sources and the reserved gap
  a_neg_touch: assert property (@(posedge clk) disable iff (reset)
    (s_wr0 and sfr_req.wdata[7:4] == 4'hC) |=> cmp0_mux.neg_sel == 12'h100)
    else $error("negative 1100 not touch reference");
  a_neg_half: assert property (@(posedge clk) disable iff (reset)
    (s_wr0 and sfr_req.wdata[7:4] == 4'hD) |=> cmp0_mux.neg_sel == 12'h200)
    else $error("negative 1101 not half supply");
  a_neg_supply: assert property (@(posedge clk) disable iff (reset)
    (s_wr0 and sfr_req.wdata[7:4] == 4'hE) |=> cmp0_mux.neg_sel == 12'h400)
    else $error("negative 1110 not regulated supply");
  a_neg_gap: assert property (@(posedge clk) disable iff (reset)
    (s_wr0 and sfr_req.wdata[7:6] == 2'b10) |=> cmp0_mux.neg_sel == 12'h000 && cmp0_reserved)
    else $error("negative 10xx not treated as reserved");

  // positive field: internal sources, the reserved gap and a comparator-1 pin route
  a_pos_half: assert property (@(posedge clk) disable iff (reset)
    (s_wr0 and sfr_req.wdata[3:0] == 4'hD) |=> cmp0_mux.pos_sel == 12'h200)
    else $error("positive 1101 not half supply");
  a_pos_battery: assert property (@(posedge clk) disable iff (reset)
    (s_wr0 and sfr_req.wdata[3:0] == 4'hE) |=> cmp0_mux.pos_sel == 12'h400)
    else $error("positive 1110 not battery supply");
  a_pos_rail: assert property (@(posedge clk) disable iff (reset)
    (s_wr0 and sfr_req.wdata[3:0] == 4'hF) |=> cmp0_mux.pos_sel == 12'h800)
    else $error("positive 1111 not main rail");
  a_pos_gap: assert property (@(posedge clk) disable iff (reset)
    (s_wr0 and sfr_req.wdata[3:2] == 2'b10) |=> cmp0_mux.pos_sel == 12'h000 && cmp0_reserved)
    else $error("positive 10xx not treated as reserved");
  a_cmp1_pos_pin: assert property (@(posedge clk) disable iff (reset)
    (s_wr1 and sfr_req.wdata[3:0] == 4'h6) |=> cmp1_mux.pos_sel == 12'h040)
    else $error("cmp1 positive 0110 not routed to seventh pin");

endmodule
`default_nettype wire

// file: sim/tb_top.sv
// tb_top: self-checking bench for the comparator input select registers.
// assumes cisr_pkg and cisr_regs are compiled first; one 125 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cisr_pkg::*;
  // stimulus and observed signals
  logic clk = 1'b0;
  logic reset = 1'b1;
  cisr_sfr_req_t sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  cisr_mux_sel_t cmp0_mux;
  cisr_mux_sel_t cmp1_mux;
  logic cmp0_reserved;
  logic cmp1_reserved;
  int fail_count = 0;
  int compares = 0;
  // clock: 8 ns period
  always #4 clk = ~clk;
  cisr_regs DUT (.clk(clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .cmp0_mux(cmp0_mux), .cmp1_mux(cmp1_mux),
    .cmp0_reserved(cmp0_reserved), .cmp1_reserved(cmp1_reserved));
  // one compare for every result kind; narrower values zero-extend
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one bus cycle; the strobe is held one cycle, then outputs settle before return
  task automatic bus(input logic [3:0] pg, input logic [7:0] a, input logic w,
      input logic [7:0] d);
    @(posedge clk);
    sfr_req <= '{page: pg, addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clk);
    sfr_req <= '0;
    #1;
  endtask
  // expected one-hot selects; reserved codes give all zero
  function automatic logic [11:0] exp_neg(input logic [3:0] c);
    if (c < 4'h7) return 12'h001 << c;
    if (c < 4'hC) return 12'h000;
    return 12'h001 << (c - 4'h4);
  endfunction
  function automatic logic [11:0] exp_pos(input logic [3:0] c);
    if (c < 4'h8) return 12'h001 << c;
    if (c < 4'hC) return 12'h000;
    return 12'h001 << (c - 4'h4);
  endfunction
  // reset state seen at the pins and through reads
  task automatic t_reset_state;
    chk(cmp0_mux.neg_sel, 12'h800);
    chk(cmp0_mux.pos_sel, 12'h800);
    chk(cmp1_mux.neg_sel, 12'h800);
    chk(cmp1_mux.pos_sel, 12'h800);
    chk({cmp0_reserved, cmp1_reserved}, 12'h000);
    bus(4'h0, CISR_CMP0_ADDR, 1'b0, 8'h00);
    chk(sfr_rdata, 12'h0FF);
    bus(4'h0, CISR_CMP1_ADDR, 1'b0, 8'h00);
    chk(sfr_rdata, 12'h0FF);
  endtask
  // every bit of both registers written and read back, 0x5A on comparator 0 and 0xA5 on comparator 1
  task automatic t_read_write;
    bus(4'h0, 8'h9F, 1'b1, 8'h5A);
    bus(4'h0, 8'h9E, 1'b1, 8'hA5);
    bus(4'h0, 8'h9F, 1'b0, 8'h00);
    chk({sfr_hit, sfr_rdata}, 12'h15A);
    bus(4'h0, 8'h9E, 1'b0, 8'h00);
    chk({sfr_hit, sfr_rdata}, 12'h1A5);
    // read answer stands a single cycle only
    @(posedge clk);
    #1;
    chk({sfr_hit, sfr_rdata}, 12'h000);
  endtask
  // all sixteen codes on both fields of both registers
  task automatic t_decode;
    logic [3:0] n;
    for (int c = 0; c < 16; c++) begin
      n = 4'(c);
      bus(4'h0, 8'h9F, 1'b1, {n, n});
      chk(cmp0_mux.neg_sel, exp_neg(n));
      chk(cmp0_mux.pos_sel, exp_pos(n));
      chk(cmp0_reserved, (exp_neg(n) == 0) || (exp_pos(n) == 0));
      // opposite codes on the two fields of comparator 1 catch swapped nibbles
      bus(4'h0, 8'h9E, 1'b1, {n, ~n});
      chk(cmp1_mux.neg_sel, exp_neg(n));
      chk(cmp1_mux.pos_sel, exp_pos(~n));
      chk(cmp1_reserved, (exp_neg(n) == 0) || (exp_pos(~n) == 0));
    end
  endtask
  // wrong page and unmapped addresses are ignored
  task automatic t_refused;
    bus(4'h1, 8'h9F, 1'b1, 8'h00);
    chk(cmp0_mux.neg_sel, 12'h800);
    bus(4'h1, 8'h9F, 1'b0, 8'h00);
    chk({sfr_hit, sfr_rdata}, 12'h000);
    bus(4'h0, 8'h9D, 1'b0, 8'h00);
    chk({sfr_hit, sfr_rdata}, 12'h000);
  endtask
  // reset in mid-run brings both registers back to all ones
  task automatic t_mid_reset;
    bus(4'h0, 8'h9F, 1'b1, 8'h00);
    bus(4'h0, 8'h9E, 1'b1, 8'h12);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    t_reset_state();
  endtask
  // write then read in the very next cycle, and read with write in one cycle
  task automatic t_back_to_back;
    @(posedge clk);
    sfr_req <= '{page: 4'h0, addr: 8'h9F, wr: 1'b1, rd: 1'b0, wdata: 8'h3C};
    @(posedge clk);
    sfr_req <= '{page: 4'h0, addr: 8'h9F, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    sfr_req <= '0;
    #1;
    chk({sfr_hit, sfr_rdata}, 12'h13C);
    chk(cmp0_mux.neg_sel, 12'h008);
    chk(cmp0_mux.pos_sel, 12'h100);
    // combined strobes: old value read back, new value stored
    @(posedge clk);
    sfr_req <= '{page: 4'h0, addr: 8'h9F, wr: 1'b1, rd: 1'b1, wdata: 8'hC3};
    @(posedge clk);
    sfr_req <= '0;
    #1;
    chk({sfr_hit, sfr_rdata}, 12'h13C);
    bus(4'h0, 8'h9F, 1'b0, 8'h00);
    chk({sfr_hit, sfr_rdata}, 12'h1C3);
    @(posedge clk);
    sfr_req <= '{page: 4'h0, addr: 8'h9E, wr: 1'b1, rd: 1'b0, wdata: 8'h5D};
    @(posedge clk);
    sfr_req <= '{page: 4'h0, addr: 8'h9E, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    sfr_req <= '0;
    #1;
    chk({sfr_hit, sfr_rdata}, 12'h15D);
    chk(cmp1_mux.neg_sel, 12'h020);
    chk(cmp1_mux.pos_sel, 12'h200);
  endtask
  // verdict and end of run
  task automatic conclude;
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #80000;
    fail_count++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    #1;
    t_reset_state();
    t_read_write();
    t_back_to_back();
    t_decode();
    t_refused();
    t_mid_reset();
    conclude();
  end
endmodule
`default_nettype wire
